// *** shared/cbfd_defines.vh ***
`ifndef CBFD_DEFINES_VH
`define CBFD_DEFINES_VH
`define CBFD_CLK_MHZ 10
`define CBFD_CNT_W 16
`define CBFD_CONFIRM_CYCLES 3'h5
`define CBFD_TXD_DOM_US 300
`define CBFD_TXD_DOM_CYC 16'h0bb8
`define CBFD_DOMINANT_CLAMP_TIME_LIMIT_US 800
`define CBFD_DOMINANT_CLAMP_TIME_LIMIT_CYC 16'h1f40
`define CBFD_SYNC_W 9
`define CBFD_FAIL_NONE 3'h0
`define CBFD_FAIL_L_GND 3'h1
`define CBFD_FAIL_H_GND 3'h2
`define CBFD_FAIL_L_BAT 3'h3
`define CBFD_FAIL_H_BAT 3'h4
`define CBFD_FAIL_L_5V 3'h5
`define CBFD_FAIL_H_5V 3'h6
`endif

// *** core/cbfd_sync.v ***
`timescale 1ns/1ps
module cbfd_sync
#(
   parameter W = 1
)
(
   input wire i_clk,
   input wire i_srst,
   input wire i_ce,
   input wire [W-1:0] i_d,
   output wire [W-1:0] o_q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   // two-stage synchroniser, first stage feeds only the second
   always @(posedge i_clk)
   begin
      // reset to the recessive idle level so no false edge follows reset
      if (i_srst)
      begin
         meta_r <= {W{1'b1}};
         sync_r <= {W{1'b1}};
      end
      else if (i_ce)
      begin
         meta_r <= i_d;
         sync_r <= meta_r;
      end
   end
   assign o_q = sync_r;
endmodule

// *** core/cbfd_core.v ***
`timescale 1ns/1ps
`include "cbfd_defines.vh"
module cbfd_core
#(
   parameter [`CBFD_CNT_W-1:0] TXD_DOM_CYC = `CBFD_TXD_DOM_CYC,
   parameter [`CBFD_CNT_W-1:0] DOMINANT_CLAMP_TIME_LIMIT_CYC = `CBFD_DOMINANT_CLAMP_TIME_LIMIT_CYC
)
(
   input wire i_clk,
   input wire i_srst,
   input wire i_ce,
   input wire i_txd,
   input wire i_rxd_pin,
   input wire i_diff_rx,
   input wire i_low_line_ground_comparator,
   input wire i_high_line_ground_comparator,
   input wire i_low_line_battery_comparator,
   input wire i_high_line_battery_comparator,
   input wire i_low_line_5v_comparator,
   input wire i_high_line_5v_comparator,
   input wire i_normal_mode,
   input wire i_mode_txrx_wr,
   input wire i_rd_bus_fail,
   input wire i_rd_receive_stuck,
   input wire i_rd_txd_dom,
   output reg o_bus_drive_en,
   output reg o_bus_dominant,
   output reg o_rxd,
   output reg o_rxd_oe,
   output reg o_bus_fail_bit,
   output reg [2:0] o_fail_code,
   output reg o_receive_stuck_bit,
   output reg o_txd_dom_bit
);
   wire [`CBFD_SYNC_W-1:0] sync_q;
   wire txd_s;
   wire rxd_s;
   wire diff_s;
   wire lg_s;
   wire hg_s;
   wire lb_s;
   wire hb_s;
   wire l5_s;
   wire h5_s;
   reg txd_d_r;
   reg diff_d_r;
   reg rxd_d_r;
   reg rec_gnd_r;
   reg rec_bat_r;
   reg rec_5v_r;
   reg seen_rec_r;
   reg [2:0] cur_code_r;
   reg [2:0] cur_cnt_r;
   reg [`CBFD_CNT_W-1:0] clamp_cnt_r;
   reg [`CBFD_CNT_W-1:0] txd_cnt_r;
   reg stuck_act_r;
   reg txd_dom_act_r;
   reg drv_lock_r;
   reg normal_d_r;
   reg [2:0] cyc_code;
   reg short_set;
   reg clamp_set;
   reg stuck_set;
   reg txd_dom_set;
   wire txd_rise;
   wire txd_fall;
   wire diff_rise;
   wire diff_fall;
   wire normal_cmd;
   wire drv_kill;
   cbfd_sync #(.W(`CBFD_SYNC_W)) u_sync
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_d({i_txd, i_rxd_pin, i_diff_rx,
            i_low_line_ground_comparator, i_high_line_ground_comparator,
            i_low_line_battery_comparator, i_high_line_battery_comparator,
            i_low_line_5v_comparator, i_high_line_5v_comparator}),
      .o_q(sync_q)
   );
   assign txd_s = sync_q[8];
   assign rxd_s = sync_q[7];
   assign diff_s = sync_q[6];
   assign lg_s = sync_q[5];
   assign hg_s = sync_q[4];
   assign lb_s = sync_q[3];
   assign hb_s = sync_q[2];
   assign l5_s = sync_q[1];
   assign h5_s = sync_q[0];
   // driver cycle edges: tx fall starts dominant, tx rise ends it
   assign txd_fall = txd_d_r & ~txd_s;
   assign txd_rise = ~txd_d_r & txd_s;
   assign diff_rise = ~diff_d_r & diff_s;
   assign diff_fall = diff_d_r & ~diff_s;
   assign normal_cmd = i_normal_mode & ~normal_d_r;
   // anything that forces the bus driver off this cycle
   assign drv_kill = stuck_set | txd_dom_set | ~i_normal_mode | drv_lock_r | stuck_act_r |
                     txd_dom_act_r;
   // per-cycle classification at end of dominant phase
   always @*
   begin
      cyc_code = `CBFD_FAIL_NONE;
      if (rec_gnd_r)
      begin
         if (!hg_s)
            cyc_code = `CBFD_FAIL_H_GND;
         else
            cyc_code = `CBFD_FAIL_L_GND;
      end
      else if (rec_bat_r)
      begin
         if (lb_s)
            cyc_code = `CBFD_FAIL_L_BAT;
         else
            cyc_code = `CBFD_FAIL_H_BAT;
      end
      else if (rec_5v_r)
      begin
         if (l5_s)
            cyc_code = `CBFD_FAIL_L_5V;
         else
            cyc_code = `CBFD_FAIL_H_5V;
      end
   end
   // event detection
   always @*
   begin
      short_set = 1'b0;
      if (txd_rise && seen_rec_r && o_bus_drive_en && cyc_code != `CBFD_FAIL_NONE &&
          cyc_code == cur_code_r && cur_cnt_r >= `CBFD_CONFIRM_CYCLES - 3'h1)
         short_set = 1'b1;
      clamp_set = (clamp_cnt_r == DOMINANT_CLAMP_TIME_LIMIT_CYC) && !diff_s;
      stuck_set = diff_rise && rxd_d_r && o_rxd_oe;
      txd_dom_set = (txd_cnt_r == TXD_DOM_CYC) && !txd_s;
   end
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         txd_d_r <= 1'b1;
         diff_d_r <= 1'b1;
         rxd_d_r <= 1'b0;
         rec_gnd_r <= 1'b0;
         rec_bat_r <= 1'b0;
         rec_5v_r <= 1'b0;
         seen_rec_r <= 1'b0;
         cur_code_r <= `CBFD_FAIL_NONE;
         cur_cnt_r <= 3'h0;
         clamp_cnt_r <= {`CBFD_CNT_W{1'b0}};
         txd_cnt_r <= {`CBFD_CNT_W{1'b0}};
         stuck_act_r <= 1'b0;
         txd_dom_act_r <= 1'b0;
         drv_lock_r <= 1'b0;
         normal_d_r <= 1'b0;
         o_bus_drive_en <= 1'b0;
         o_bus_dominant <= 1'b0;
         o_rxd <= 1'b1;
         o_rxd_oe <= 1'b1;
         o_bus_fail_bit <= 1'b0;
         o_fail_code <= `CBFD_FAIL_NONE;
         o_receive_stuck_bit <= 1'b0;
         o_txd_dom_bit <= 1'b0;
      end
      else if (i_ce)
      begin
         txd_d_r <= txd_s;
         diff_d_r <= diff_s;
         rxd_d_r <= rxd_s;
         normal_d_r <= i_normal_mode;
         // recessive comparator sample taken as dominant begins
         if (txd_fall)
         begin
            rec_gnd_r <= ~lg_s & ~hg_s;
            rec_bat_r <= lb_s & hb_s;
            rec_5v_r <= l5_s & h5_s;
            seen_rec_r <= o_bus_drive_en;
         end
         // five-cycle confirmation
         if (txd_rise && seen_rec_r && o_bus_drive_en)
         begin
            seen_rec_r <= 1'b0;
            if (cyc_code != cur_code_r || cyc_code == `CBFD_FAIL_NONE)
            begin
               cur_code_r <= cyc_code;
               cur_cnt_r <= (cyc_code == `CBFD_FAIL_NONE) ? 3'h0 : 3'h1;
            end
            else if (cur_cnt_r != `CBFD_CONFIRM_CYCLES)
               cur_cnt_r <= cur_cnt_r + 3'h1;
         end
         // dominant clamp timer on the bus state
         if (diff_s)
            clamp_cnt_r <= {`CBFD_CNT_W{1'b0}};
         else if (clamp_cnt_r != DOMINANT_CLAMP_TIME_LIMIT_CYC)
            clamp_cnt_r <= clamp_cnt_r + 1'b1;
         // transmit dominant timer, only while driving
         if (txd_s || !o_bus_drive_en)
            txd_cnt_r <= {`CBFD_CNT_W{1'b0}};
         else if (txd_cnt_r != TXD_DOM_CYC)
            txd_cnt_r <= txd_cnt_r + 1'b1;
         // receive output stuck condition
         if (stuck_set)
            stuck_act_r <= 1'b1;
         else if (!txd_s)
            stuck_act_r <= 1'b0;
         // transmit permanent dominant condition
         if (txd_dom_set)
            txd_dom_act_r <= 1'b1;
         else if (normal_cmd || (txd_s && diff_fall))
            txd_dom_act_r <= 1'b0;
         // flags: set wins over read
         o_bus_fail_bit <= short_set | clamp_set | (o_bus_fail_bit & ~i_rd_bus_fail);
         if (short_set)
            o_fail_code <= cyc_code;
         else if (i_rd_bus_fail && !clamp_set)
            o_fail_code <= `CBFD_FAIL_NONE;
         o_receive_stuck_bit <= stuck_set | (stuck_act_r & ~txd_s) |
                                (o_receive_stuck_bit & ~i_rd_receive_stuck);
         o_txd_dom_bit <= txd_dom_set | (o_txd_dom_bit & ~i_rd_txd_dom);
         // driver lockout until faults gone, flags read and mode rewritten
         if (stuck_set || txd_dom_set)
            drv_lock_r <= 1'b1;
         else if (i_mode_txrx_wr && !stuck_act_r && !txd_dom_act_r &&
                  !o_receive_stuck_bit && !o_txd_dom_bit)
            drv_lock_r <= 1'b0;
         // bus driver enable
         if (drv_kill)
            o_bus_drive_en <= 1'b0;
         else if (txd_s)
            o_bus_drive_en <= 1'b1;
         o_bus_dominant <= o_bus_drive_en & ~txd_s & ~drv_kill;
         // receive output driver
         if (stuck_set)
            o_rxd_oe <= 1'b0;
         else if (!stuck_act_r)
            o_rxd_oe <= 1'b1;
         o_rxd <= diff_s;
      end
   end
endmodule

// *** verification/cbfd_chk.sv ***
`timescale 1ns/1ps
module cbfd_chk
#(
   parameter [15:0] TXD_DOM_CYC = 16'h0014
)
(
   input wire i_clk,
   input wire i_srst,
   input wire i_normal_mode,
   input wire i_rd_txd_dom,
   input wire o_bus_drive_en,
   input wire o_bus_dominant,
   input wire o_rxd_oe,
   input wire o_bus_fail_bit,
   input wire [2:0] o_fail_code,
   input wire o_receive_stuck_bit,
   input wire o_txd_dom_bit
);
   int dom_r;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   sequence s_off;
      !o_bus_drive_en && !o_bus_dominant;
   endsequence
   sequence s_stuck;
      o_receive_stuck_bit && !o_bus_drive_en;
   endsequence
   // length of the present dominant drive
   always @(posedge i_clk)
      dom_r <= (i_srst || !o_bus_dominant) ? 0 : dom_r + 1;
   a_drive_needs_normal:
   assert property (o_bus_drive_en |-> $past(i_normal_mode)) else $error("drive outside normal");
   a_dom_needs_drive:
   assert property (o_bus_dominant |-> o_bus_drive_en) else $error("dominant while off");
   a_txd_dom_off:
   assert property ($rose(o_txd_dom_bit) |-> ##[0:1] s_off) else $error("driver on after timeout");
   a_stuck_kills_drive:
   assert property ($fell(o_rxd_oe) |-> s_stuck) else $error("stuck without flag");
   a_oe_gates_drive:
   assert property (!o_rxd_oe |-> !o_bus_drive_en) else $error("drive with rxd off");
   a_flag_holds:
   assert property (o_txd_dom_bit && !i_rd_txd_dom |=> o_txd_dom_bit) else $error("flag lost");
   a_code_with_flag:
   assert property ($changed(o_fail_code) && o_fail_code != 3'h0 |-> o_bus_fail_bit)
      else $error("code without flag");
   a_dom_bounded:
   assert property (dom_r <= TXD_DOM_CYC + 3) else $error("dominant too long");
endmodule

// *** verification/cbfd_bus_model.sv ***
`timescale 1ns/1ps
module cbfd_bus_model
(
   input wire i_drive_en,
   input wire i_dominant,
   input wire i_clamp,
   input wire i_h_gnd,
   output wire o_diff_rx,
   output wire o_lg,
   output wire o_hg
);
   wire dom = i_drive_en & i_dominant;
   // a grounded high line drags both lines low in either state
   assign o_diff_rx = ~(dom | i_clamp);
   assign o_lg = ~dom & ~i_h_gnd;
   assign o_hg = ~i_h_gnd;
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`include "cbfd_defines.vh"
module tb_top;
   localparam [15:0] TXC = 16'h0014;
   logic i_clk = 0, i_srst = 1, i_txd = 1, i_normal_mode = 0, i_mode_txrx_wr = 0;
   logic i_rd_bus_fail = 0, i_rd_receive_stuck = 0, i_rd_txd_dom = 0;
   logic clamp = 0, h_gnd = 0, stuck = 0, trf = 0, prv = 1, ce = 1, bat = 0;
   logic [3:0] txh = 4'hf, dfh = 4'hf;
   logic [31:0] rnd = 32'h0000_50c0;
   int n_mismatch = 0, n_checks = 0, n;
   wire i_diff_rx, lg, hg, o_bus_drive_en, o_bus_dominant, o_rxd, o_rxd_oe;
   wire o_bus_fail_bit, o_receive_stuck_bit, o_txd_dom_bit;
   wire [2:0] o_fail_code;
   wire i_rxd_pin = stuck | o_rxd;
   cbfd_core #(.TXD_DOM_CYC(TXC), .DOMINANT_CLAMP_TIME_LIMIT_CYC(16'h001e)) DUT (.i_clk, .i_srst, .i_ce(ce),
      .i_txd, .i_rxd_pin, .i_diff_rx, .i_low_line_ground_comparator(lg),
      .i_high_line_ground_comparator(hg), .i_low_line_battery_comparator(bat),
      .i_high_line_battery_comparator(bat), .i_low_line_5v_comparator(1'b0),
      .i_high_line_5v_comparator(1'b0), .i_normal_mode, .i_mode_txrx_wr, .i_rd_bus_fail,
      .i_rd_receive_stuck, .i_rd_txd_dom, .o_bus_drive_en, .o_bus_dominant, .o_rxd,
      .o_rxd_oe, .o_bus_fail_bit, .o_fail_code, .o_receive_stuck_bit, .o_txd_dom_bit);
   cbfd_bus_model MDL (.i_drive_en(o_bus_drive_en), .i_dominant(o_bus_dominant),
      .i_clamp(clamp), .i_h_gnd(h_gnd), .o_diff_rx(i_diff_rx), .o_lg(lg), .o_hg(hg));
   initial forever #50 i_clk = ~i_clk;
   // reference: pins seen three edges earlier
   always @(posedge i_clk)
   begin
      txh <= {txh[2:0], i_txd};
      dfh <= {dfh[2:0], i_diff_rx};
   end
   always @(negedge i_clk)
      if (trf)
      begin
         chk_bit("dominant", ~txh[2], o_bus_dominant);
         chk_bit("rxd", dfh[2], o_rxd);
      end
   function logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic pick(input int s);
      pick = s == 0 ? o_bus_drive_en : s == 1 ? o_rxd_oe : o_bus_fail_bit;
   endfunction
   task chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %b seen %b", nm, e, g);
      end
   endtask
   task chk_code(input logic [2:0] e);
      n_checks++;
      if (o_fail_code !== e)
      begin
         n_mismatch++;
         $display("BAD fail_code exp %0d seen %0d", e, o_fail_code);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task wt(input int s, input logic v);
      n = 0;
      while (pick(s) !== v && n < 80)
      begin
         cyc(1);
         n++;
      end
      if (n == 80)
      begin
         n_mismatch++;
         $display("BAD wait%0d exp %b seen %b", s, v, pick(s));
         finish_test;
      end
   endtask
   task rd_all;
      {i_rd_bus_fail, i_rd_receive_stuck, i_rd_txd_dom} = 3'h7;
      cyc(1);
      {i_rd_bus_fail, i_rd_receive_stuck, i_rd_txd_dom} = 3'h0;
      cyc(1);
   endtask
   task recover;
      rd_all;
      i_mode_txrx_wr = 1;
      cyc(1);
      i_mode_txrx_wr = 0;
      wt(0, 1);
   endtask
   task scyc(input int k);
      repeat (k)
      begin
         i_txd = 0;
         cyc(8);
         i_txd = 1;
         cyc(8);
      end
   endtask
   initial
   begin
      cyc(6);
      i_srst = 0;
      cyc(5);
      chk_bit("drive_en", 1'b0, o_bus_drive_en);
      i_normal_mode = 1;
      wt(0, 1);
      // frozen state must ignore a long dominant on the pin
      ce = 0;
      i_txd = 0;
      cyc(30);
      chk_bit("ce_drive_en", 1'b1, o_bus_drive_en);
      chk_bit("ce_txd_dom", 1'b0, o_txd_dom_bit);
      i_txd = 1;
      ce = 1;
      cyc(4);
      $display("ce hold done");
      trf = 1;
      repeat (16)
      begin
         rnd = lfsr(rnd);
         i_txd = prv ? rnd[0] : 1'b1;
         prv = i_txd;
         cyc(8);
      end
      trf = 0;
      i_txd = 1;
      cyc(8);
      $display("traffic done");
      clamp = 1;
      cyc(25);
      chk_bit("bus_fail", 1'b0, o_bus_fail_bit);
      wt(2, 1);
      clamp = 0;
      cyc(8);
      chk_bit("rxd_oe", 1'b1, o_rxd_oe);
      rd_all;
      chk_bit("bus_fail", 1'b0, o_bus_fail_bit);
      $display("clamp done");
      h_gnd = 1;
      scyc(3);
      h_gnd = 0;
      scyc(1);
      h_gnd = 1;
      scyc(4);
      chk_bit("bus_fail", 1'b0, o_bus_fail_bit);
      scyc(1);
      chk_bit("bus_fail", 1'b1, o_bus_fail_bit);
      chk_code(`CBFD_FAIL_H_GND);
      rd_all;
      scyc(1);
      chk_bit("bus_fail", 1'b1, o_bus_fail_bit);
      h_gnd = 0;
      rd_all;
      bat = 1;
      scyc(5);
      chk_bit("bus_fail", 1'b1, o_bus_fail_bit);
      chk_code(`CBFD_FAIL_L_BAT);
      bat = 0;
      rd_all;
      $display("short done");
      i_txd = 0;
      wt(0, 0);
      chk_bit("dom_time", 1'b1, n >= TXC && n <= TXC + 5);
      chk_bit("txd_dom", 1'b1, o_txd_dom_bit);
      chk_bit("dominant", 1'b0, o_bus_dominant);
      i_txd = 1;
      cyc(10);
      chk_bit("drive_en", 1'b0, o_bus_drive_en);
      i_normal_mode = 0;
      cyc(1);
      i_normal_mode = 1;
      recover;
      i_txd = 0;
      wt(0, 0);
      i_txd = 1;
      cyc(4);
      // receive side falls while transmit is recessive
      clamp = 1;
      cyc(4);
      clamp = 0;
      recover;
      $display("txd dominant done");
      stuck = 1;
      i_txd = 0;
      cyc(8);
      i_txd = 1;
      wt(1, 0);
      chk_bit("stuck", 1'b1, o_receive_stuck_bit);
      chk_bit("drive_en", 1'b0, o_bus_drive_en);
      stuck = 0;
      i_txd = 0;
      wt(1, 1);
      i_txd = 1;
      cyc(4);
      recover;
      $display("stuck done");
      finish_test;
   end
endmodule
bind cbfd_core cbfd_chk #(.TXD_DOM_CYC(TXD_DOM_CYC)) CHK (.i_clk, .i_srst, .i_normal_mode,
   .i_rd_txd_dom, .o_bus_drive_en, .o_bus_dominant, .o_rxd_oe, .o_bus_fail_bit,
   .o_fail_code, .o_receive_stuck_bit, .o_txd_dom_bit);
